//--- design/module_reset_status_pkg.sv
package module_reset_status_pkg;

    localparam int          CLK_HZ              = 100_000_000;
    // Factory-restore hold threshold in seconds
    localparam int          RESTORE_HOLD_S      = 7;
    localparam longint      RESTORE_HOLD_CYC    = longint'(RESTORE_HOLD_S)
                                                  * longint'(CLK_HZ);
    // Blink period one second, half on and half off
    localparam int          BLINK_PERIOD_MS     = 1000;
    localparam int          BLINK_HALF_CYC      = (CLK_HZ / 1000)
                                                  * (BLINK_PERIOD_MS / 2);
    // Debounce settle time in microseconds
    localparam int          DEBOUNCE_US         = 1000;
    localparam int          DEBOUNCE_CYC        = (CLK_HZ / 1_000_000)
                                                  * DEBOUNCE_US;
    localparam int          CFG_PIN_COUNT       = 13;
    localparam int          SPI_IRQ_PIN         = 2;
    localparam int          SPI_MISO_PIN        = 3;
    localparam int          SPI_MOSI_PIN        = 4;
    localparam int          SPI_CLOCK_PIN       = 7;
    localparam int          SPI_SELECT_PIN      = 8;
    localparam logic [12:0] CFG_OE_RESET        = 13'h0000;

    typedef enum logic [1:0] {
        SEL_GPIO,
        SEL_SPI
    } pin_sel_type;

    typedef enum {
        ST_RUN,
        ST_HOLD,
        ST_ARMED,
        ST_RESTORE
    } restore_state_type;

endpackage : module_reset_status_pkg

//--- design/input_conditioner.sv
`timescale 1ns/1ps
`default_nettype none

module input_conditioner #(
    parameter int DEBOUNCE_CYCLES = 100_000
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic pin_i,
    output logic      level_o,
    output logic      rise_o,
    output logic      fall_o
);
    localparam int CW = $clog2(DEBOUNCE_CYCLES + 1);

    logic          sync1;
    logic          sync2;
    logic          sync3;
    logic [CW-1:0] count;
    logic          level;
    logic          level_d;
    wire           agree   = (sync2 == sync3);
    wire           differ  = agree && (sync3 != level);
    wire           settled = (count == CW'(DEBOUNCE_CYCLES - 1));

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1   <= 1'b1;
            sync2   <= 1'b1;
            sync3   <= 1'b1;
            count   <= '0;
            level   <= 1'b1;
            level_d <= 1'b1;
        end else begin
            sync1   <= pin_i;
            sync2   <= sync1;
            sync3   <= sync2;
            level_d <= level;
            if (!differ) begin
                count <= '0;
            end else if (settled) begin
                count <= '0;
                level <= sync3;
            end else begin
                count <= count + 1'b1;
            end
        end
    end

    assign level_o = level;
    assign rise_o  = level & ~level_d;
    assign fall_o  = ~level & level_d;

endmodule // input_conditioner

`default_nettype wire

//--- design/module_reset_status_control.sv
// Behaviour
// - In normal running the system indicator stays steadily lit.
// - After seven seconds held, the system indicator blinks once per second.
// - Restore reboot happens only on button release, never while held.
// - Wireless indicator lit only while station is associated.
// - System indicator output is active high.
// - Wireless indicator output is active low.
// - Wired indicator low on link, toggling for traffic activity.
// - Thirteen configurable pins, all inputs after reset.
// - SPI roles on pins 2, 3, 4, 7 and 8.
// - Hardware reboot input low restarts the processor, no software.
// - Restore input polled; seven seconds low restores defaults, reboots.
// - Only a rising wake edge leaves sleep, never a level.
// - Shutdown indicator asserted throughout shutdown or standby.
// - Reboot, restore and wake pins are inputs in reset.
// - Pins float as inputs until firmware configures them.
`timescale 1ns/1ps
`default_nettype none

module module_reset_status_control #(
    parameter longint RESTORE_CYCLES  =
        module_reset_status_pkg::RESTORE_HOLD_CYC,
    parameter int     BLINK_CYCLES    =
        module_reset_status_pkg::BLINK_HALF_CYC,
    parameter int     DEBOUNCE_CYCLES =
        module_reset_status_pkg::DEBOUNCE_CYC
) (
    input  wire logic        CLK_I,
    input  wire logic        RST_N_I,
    input  wire logic        FACTORY_RESTORE_N_I,
    input  wire logic        WAKE_I,
    input  wire logic        SLEEP_REQ_I,
    input  wire logic        STATION_ASSOCIATED_I,
    input  wire logic        WIRED_LINK_I,
    input  wire logic        WIRED_ACTIVITY_I,
    input  wire logic [12:0] CFG_PIN_I,
    input  wire logic [12:0] CFG_PIN_OUT_I,
    input  wire logic [12:0] CFG_PIN_DIR_I,
    input  wire logic        CFG_PIN_DIR_WE_I,
    input  wire logic        SPI_MODE_I,
    input  wire logic        SPI_MISO_I,
    input  wire logic        SPI_CLOCK_I,
    input  wire logic        SPI_SELECT_I,
    output logic             SPI_IRQ_O,
    output logic             SPI_MOSI_O,
    output logic [12:0]      CFG_PIN_O,
    output logic [12:0]      CFG_PIN_OE_O,
    output logic             SYSTEM_STATUS_INDICATOR_O,
    output logic             WIRELESS_LINK_INDICATOR_N_O,
    output logic             WIRED_LINK_ACTIVITY_INDICATOR_N_O,
    output logic             SHUTDOWN_INDICATOR_O,
    output logic             RESTORE_DEFAULTS_O,
    output logic             PROCESSOR_RESET_N_O
);
    import module_reset_status_pkg::*;

    localparam int BW = $clog2(BLINK_CYCLES + 1);

    // Reboot input releases through two flops
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    logic restore_level;
    logic wake_level_n;
    logic wake_rise;

    input_conditioner #(
        .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
    ) u_restore_cond (
        .clk_i  (CLK_I),
        .rst_n_i(rst_n),
        .pin_i  (FACTORY_RESTORE_N_I),
        .level_o(restore_level),
        .rise_o (),
        .fall_o ()
    );

    input_conditioner #(
        .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
    ) u_wake_cond (
        .clk_i  (CLK_I),
        .rst_n_i(rst_n),
        .pin_i  (~WAKE_I),         // Idle low meets the high reset level
        .level_o(wake_level_n),
        .rise_o (),
        .fall_o (wake_rise)
    );

    // Factory-restore sequencer
    restore_state_type state;
    restore_state_type next_state;
    logic [39:0]       hold_count;
    logic              reboot_pulse;
    wire               pressed   = ~restore_level;
    wire               held_long = (hold_count
                                   == 40'(RESTORE_CYCLES - 1));

    always_comb begin
        next_state = state;
        case (state)
            ST_RUN: begin
                if (pressed) begin
                    next_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (!pressed) begin
                    next_state = ST_RUN;
                end else if (held_long) begin
                    next_state = ST_ARMED;
                end
            end
            ST_ARMED: begin
                if (!pressed) begin
                    next_state = ST_RESTORE;
                end
            end
            ST_RESTORE: begin
                next_state = ST_RUN;
            end
            default: begin
                next_state = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            state      <= ST_RUN;
            hold_count <= '0;
        end else begin
            state <= next_state;
            if (state == ST_HOLD && pressed && !held_long) begin
                hold_count <= hold_count + 1'b1;
            end else if (state != ST_HOLD) begin
                hold_count <= '0;
            end
        end
    end

    assign reboot_pulse = (state == ST_RESTORE);

    // One-second blink timebase
    logic [BW-1:0] blink_count;
    logic          blink_phase;
    wire           blink_wrap = (blink_count == BW'(BLINK_CYCLES - 1));

    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            blink_count <= '0;
            blink_phase <= 1'b1;
        end else if (state != ST_ARMED) begin
            blink_count <= '0;
            blink_phase <= 1'b1;
        end else if (blink_wrap) begin
            blink_count <= '0;
            blink_phase <= ~blink_phase;
        end else begin
            blink_count <= blink_count + 1'b1;
        end
    end

    // Sleep state: entered on request, left on wake rising edge
    logic asleep;
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            asleep <= 1'b0;
        end else if (wake_rise) begin
            asleep <= 1'b0;
        end else if (SLEEP_REQ_I && wake_level_n) begin
            asleep <= 1'b1;
        end
    end

    // Wired activity toggle
    logic act_d;
    logic act_blink;
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            act_d     <= 1'b0;
            act_blink <= 1'b0;
        end else begin
            act_d <= WIRED_ACTIVITY_I;
            if (!WIRED_LINK_I) begin
                act_blink <= 1'b0;
            end else if (WIRED_ACTIVITY_I && !act_d) begin
                act_blink <= ~act_blink;
            end
        end
    end

    // Pin direction: all inputs until firmware writes
    logic [12:0] pin_dir;
    logic [12:0] pin_out;
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            pin_dir <= CFG_OE_RESET;
            pin_out <= '0;
        end else begin
            pin_out <= CFG_PIN_OUT_I;
            if (CFG_PIN_DIR_WE_I) begin
                pin_dir <= CFG_PIN_DIR_I;
            end
        end
    end

    // SPI alternate roles, pin n is bit n-1
    wire [12:0] spi_oe_mask = 13'(1) << (SPI_MISO_PIN - 1);
    logic [12:0] spi_out;
    always_comb begin
        spi_out                     = '0;
        spi_out[SPI_MISO_PIN - 1]   = SPI_MISO_I;
    end
    wire [12:0] next_oe  = SPI_MODE_I
                         ? ((pin_dir & ~13'h00CE) | spi_oe_mask)
                         : pin_dir;
    wire [12:0] next_out = SPI_MODE_I
                         ? ((pin_out & ~spi_oe_mask) | spi_out)
                         : pin_out;

    logic status_ind;
    logic assoc_ind_n;
    logic wired_led_n;
    logic shut_ind;
    logic restore_q;
    logic [12:0] cfg_oe;
    logic [12:0] cfg_out;
    logic spi_irq;
    logic spi_mosi;
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            status_ind  <= 1'b0;
            assoc_ind_n <= 1'b1;
            wired_led_n <= 1'b1;
            shut_ind    <= 1'b0;
            restore_q   <= 1'b0;
            cfg_oe      <= CFG_OE_RESET;
            cfg_out     <= '0;
            spi_irq     <= 1'b0;
            spi_mosi    <= 1'b0;
        end else begin
            status_ind  <= (state == ST_ARMED) ? blink_phase
                                               : 1'b1;
            assoc_ind_n <= ~STATION_ASSOCIATED_I;
            wired_led_n <= ~WIRED_LINK_I | act_blink;
            shut_ind    <= asleep;
            restore_q   <= reboot_pulse;
            cfg_oe      <= next_oe;
            cfg_out     <= next_out;
            spi_irq     <= SPI_MODE_I & ~CFG_PIN_I[SPI_IRQ_PIN - 1];
            spi_mosi    <= CFG_PIN_I[SPI_MOSI_PIN - 1];
        end
    end

    assign SYSTEM_STATUS_INDICATOR_O         = status_ind;
    assign WIRELESS_LINK_INDICATOR_N_O       = assoc_ind_n;
    assign WIRED_LINK_ACTIVITY_INDICATOR_N_O = wired_led_n;
    assign SHUTDOWN_INDICATOR_O              = shut_ind;
    assign RESTORE_DEFAULTS_O                = restore_q;
    assign PROCESSOR_RESET_N_O               = rst_n & ~restore_q;
    assign CFG_PIN_OE_O                      = cfg_oe;
    assign CFG_PIN_O                         = cfg_out;
    assign SPI_IRQ_O                         = spi_irq;
    assign SPI_MOSI_O                        = spi_mosi;

endmodule // module_reset_status_control

`default_nettype wire

//--- verification/module_reset_status_control_properties.sv
`timescale 1ns/1ps
`default_nettype none

module reset_status_checker #(
    parameter longint RESTORE_CYCLES  = 200,
    parameter int     DEBOUNCE_CYCLES = 4
) (
    input wire logic        CLK_I,
    input wire logic        RST_N_I,
    input wire logic        FACTORY_RESTORE_N_I,
    input wire logic        WAKE_I,
    input wire logic        STATION_ASSOCIATED_I,
    input wire logic        WIRED_LINK_I,
    input wire logic [12:0] CFG_PIN_OE_O,
    input wire logic        SYSTEM_STATUS_INDICATOR_O,
    input wire logic        WIRELESS_LINK_INDICATOR_N_O,
    input wire logic        WIRED_LINK_ACTIVITY_INDICATOR_N_O,
    input wire logic        SHUTDOWN_INDICATOR_O,
    input wire logic        RESTORE_DEFAULTS_O,
    input wire logic        PROCESSOR_RESET_N_O
);
    logic [3:0]  rel;
    logic [31:0] lo_cnt;
    logic [31:0] last_lo;
    logic [31:0] hi_cnt;
    logic        ready;
    assign ready = rel[3];

    // Press length and time since release, seen at the pin
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rel     <= 4'h0;
            lo_cnt  <= 32'h0;
            last_lo <= 32'h0;
            hi_cnt  <= 32'h0;
        end else begin
            rel    <= {rel[2:0], 1'b1};
            lo_cnt <= FACTORY_RESTORE_N_I ? 32'h0 : lo_cnt + 32'h1;
            if (FACTORY_RESTORE_N_I && lo_cnt != 32'h0) begin
                last_lo <= lo_cnt;
            end
            if (!FACTORY_RESTORE_N_I) begin
                hi_cnt <= 32'h0;
            end else if (hi_cnt < 32'h3E8) begin
                hi_cnt <= hi_cnt + 32'h1;
            end
        end
    end

    default clocking dc @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);

    a_pins_in_reset: assert property (disable iff (1'b0)
        !RST_N_I |-> CFG_PIN_OE_O == 13'h0000 && !PROCESSOR_RESET_N_O)
        else $error("pins driven or processor running in reset");
    a_sys_steady: assert property (ready && hi_cnt > 32'h20 |->
        SYSTEM_STATUS_INDICATOR_O) else $error("system indicator not lit");
    a_no_early_blink: assert property (ready && !FACTORY_RESTORE_N_I &&
        lo_cnt < RESTORE_CYCLES |-> SYSTEM_STATUS_INDICATOR_O)
        else $error("blinking before hold threshold");
    a_blink_phase: assert property (ready && !FACTORY_RESTORE_N_I &&
        $changed(SYSTEM_STATUS_INDICATOR_O) |=>
        $stable(SYSTEM_STATUS_INDICATOR_O) [*5]) else $error("blink too fast");
    a_wlan_follow: assert property (ready && $past(ready) &&
        STATION_ASSOCIATED_I == $past(STATION_ASSOCIATED_I) &&
        STATION_ASSOCIATED_I == $past(STATION_ASSOCIATED_I, 2) |->
        WIRELESS_LINK_INDICATOR_N_O == !STATION_ASSOCIATED_I)
        else $error("wireless indicator wrong");
    a_wired_dark: assert property (ready && !WIRED_LINK_I &&
        !$past(WIRED_LINK_I) && !$past(WIRED_LINK_I, 2) |->
        WIRED_LINK_ACTIVITY_INDICATOR_N_O) else $error("wired lit without link");
    a_pulse_pair: assert property (RESTORE_DEFAULTS_O |->
        !PROCESSOR_RESET_N_O ##1 !RESTORE_DEFAULTS_O)
        else $error("restore pulse malformed");
    a_after_release: assert property (RESTORE_DEFAULTS_O |->
        hi_cnt >= DEBOUNCE_CYCLES && last_lo + 32'h4 >= RESTORE_CYCLES)
        else $error("restore while held or press too short");
    a_wake_edge: assert property (ready && $fell(SHUTDOWN_INDICATOR_O) |->
        WAKE_I && $past(WAKE_I, 4)) else $error("left sleep without wake");
endmodule // reset_status_checker

bind module_reset_status_control reset_status_checker #(
    .RESTORE_CYCLES (RESTORE_CYCLES),
    .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
) u_checker (
    .CLK_I(CLK_I), .RST_N_I(RST_N_I), .WAKE_I(WAKE_I),
    .FACTORY_RESTORE_N_I(FACTORY_RESTORE_N_I),
    .STATION_ASSOCIATED_I(STATION_ASSOCIATED_I),
    .WIRED_LINK_I(WIRED_LINK_I), .CFG_PIN_OE_O(CFG_PIN_OE_O),
    .SYSTEM_STATUS_INDICATOR_O(SYSTEM_STATUS_INDICATOR_O),
    .WIRELESS_LINK_INDICATOR_N_O(WIRELESS_LINK_INDICATOR_N_O),
    .WIRED_LINK_ACTIVITY_INDICATOR_N_O(WIRED_LINK_ACTIVITY_INDICATOR_N_O),
    .SHUTDOWN_INDICATOR_O(SHUTDOWN_INDICATOR_O),
    .RESTORE_DEFAULTS_O(RESTORE_DEFAULTS_O),
    .PROCESSOR_RESET_N_O(PROCESSOR_RESET_N_O)
);

`default_nettype wire

//--- verification/host_board_model.sv
`timescale 1ns/1ps
`default_nettype none

module host_board_model (
    input  wire logic clk_i,
    input  wire logic shutdown_i,
    output logic      restore_n_o,
    output logic      wake_o,
    output logic      ext_power_o
);
    // External rail off while the module sleeps
    assign ext_power_o = ~shutdown_i;

    // Button released and wake low at power-up
    initial begin
        restore_n_o = 1'b1;
        wake_o      = 1'b0;
    end

    // Caller times the hold; long presses exceed the threshold
    task automatic button(input logic lvl);
        @(posedge clk_i);
        restore_n_o <= lvl;
    endtask

    task automatic wake(input logic lvl);
        @(posedge clk_i);
        wake_o <= lvl;
    endtask
endmodule // host_board_model

`default_nettype wire

//--- verification/module_reset_status_control_test.sv
`timescale 1ns/1ps
`default_nettype none

module module_reset_status_control_test;
    localparam int RC = 200;
    localparam int BC = 10;
    localparam int DC = 4;
    logic        clk, rst_n, sleep_req, assoc, link, act, dir_we, spi_mode;
    logic        miso, restore_n, wake, spi_irq, mosi, sys_ind, wlan_n;
    logic        wired_n, shut, pulse, cpu_rst_n;
    logic        spi_clk, spi_sel, ext_power;
    logic [12:0] pin_in, pin_out, pin_dir, pin_o, pin_oe, leds;
    int          errors, comparisons, cycles, pulses, k;

    assign leds = {8'h00, cpu_rst_n, shut, wired_n, wlan_n, sys_ind};

    host_board_model hb (
        .clk_i(clk), .shutdown_i(shut), .restore_n_o(restore_n),
        .wake_o(wake), .ext_power_o(ext_power)
    );

    module_reset_status_control #(
        .RESTORE_CYCLES(RC), .BLINK_CYCLES(BC), .DEBOUNCE_CYCLES(DC)
    ) DUT (
        .CLK_I(clk), .RST_N_I(rst_n), .FACTORY_RESTORE_N_I(restore_n),
        .WAKE_I(wake), .SLEEP_REQ_I(sleep_req),
        .STATION_ASSOCIATED_I(assoc), .WIRED_LINK_I(link),
        .WIRED_ACTIVITY_I(act), .CFG_PIN_I(pin_in), .CFG_PIN_OUT_I(pin_out),
        .CFG_PIN_DIR_I(pin_dir), .CFG_PIN_DIR_WE_I(dir_we),
        .SPI_MODE_I(spi_mode), .SPI_MISO_I(miso), .SPI_CLOCK_I(spi_clk),
        .SPI_SELECT_I(spi_sel), .SPI_IRQ_O(spi_irq), .SPI_MOSI_O(mosi),
        .CFG_PIN_O(pin_o), .CFG_PIN_OE_O(pin_oe),
        .SYSTEM_STATUS_INDICATOR_O(sys_ind),
        .WIRELESS_LINK_INDICATOR_N_O(wlan_n),
        .WIRED_LINK_ACTIVITY_INDICATOR_N_O(wired_n),
        .SHUTDOWN_INDICATOR_O(shut), .RESTORE_DEFAULTS_O(pulse),
        .PROCESSOR_RESET_N_O(cpu_rst_n)
    );

    always #5 clk = ~clk;

    task automatic check(input logic [12:0] seen, input logic [12:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Counts negative edges until the system indicator changes
    task automatic wait_change;
        logic lvl;
        lvl = sys_ind;
        k = 0;
        while (sys_ind === lvl && k < 50) begin
            @(negedge clk);
            k++;
        end
    endtask

    // Restore pulses that come with the processor reset
    always @(posedge clk) begin
        cycles++;
        if (pulse === 1'b1 && cpu_rst_n === 1'b0) pulses++;
        if (cycles == 3000) begin
            errors++;
            close_out();
        end
    end

    task automatic t_leds;
        step(6);
        #1 check(leds, 13'h0017);
        check(pin_oe, 13'h0000);
        step(1);
        assoc <= 1'b1;
        step(4);
        #1 check(leds, 13'h0015);
        step(1);
        assoc <= 1'b0;
        link <= 1'b1;
        step(4);
        #1 check(leds, 13'h0013);
        step(1);
        act <= 1'b1;
        step(4);
        #1 check(leds, 13'h0017);
        step(1);
        act <= 1'b0;
        link <= 1'b0;
    endtask

    task automatic t_restore;
        hb.button(1'b0);
        step(RC / 2);
        #1 check(leds, 13'h0017);
        hb.button(1'b1);
        step(40);
        #1 check(13'(pulses), 13'h0000);
        hb.button(1'b0);
        step(RC + 30);
        @(negedge clk);
        wait_change;
        wait_change;
        check(13'(k), 13'(BC));
        check(13'(pulses), 13'h0000);
        hb.button(1'b1);
        step(30);
        #1 check(13'(pulses), 13'h0001);
    endtask

    task automatic t_sleep;
        step(1);
        sleep_req <= 1'b1;
        step(3);
        sleep_req <= 1'b0;
        step(20);
        #1 check({12'h000, shut}, 13'h0001);
        check({12'h000, ext_power}, 13'h0000);
        hb.wake(1'b1);
        step(20);
        #1 check({12'h000, shut}, 13'h0000);
        check({12'h000, ext_power}, 13'h0001);
        hb.wake(1'b0);
    endtask

    task automatic t_pins;
        step(1);
        pin_dir <= 13'h1FFF;
        pin_out <= 13'h0A5A;
        dir_we <= 1'b1;
        step(1);
        dir_we <= 1'b0;
        step(2);
        #1 check(pin_oe, 13'h1FFF);
        check(pin_o, 13'h0A5A);
        step(1);
        pin_dir <= 13'h1FFF;
        dir_we <= 1'b1;
        spi_mode <= 1'b1;
        spi_clk <= 1'b1;
        spi_sel <= 1'b1;
        miso <= 1'b1;
        pin_in <= 13'h0008;
        step(1);
        dir_we <= 1'b0;
        step(3);
        #1 check(pin_oe, 13'h1F35);
        check({10'h000, spi_irq, mosi, pin_o[2]}, 13'h0007);
        step(1);
        miso <= 1'b0;
        pin_in <= 13'h0002;
        step(3);
        #1 check({10'h000, spi_irq, mosi, pin_o[2]}, 13'h0000);
        step(1);
        rst_n <= 1'b0;
        step(2);
        #1 check(pin_oe, 13'h0000);
        check(leds, 13'h0006);
        step(1);
        rst_n <= 1'b1;
        spi_mode <= 1'b0;
        step(8);
        #1 check(leds, 13'h0017);
    endtask

    initial begin
        clk = 1'b0;
        {rst_n, sleep_req, assoc, link, act, dir_we, spi_mode, miso} = 8'h00;
        pin_in = 13'h0000;
        {spi_clk, spi_sel} = 2'h0;
        pin_out = 13'h0000;
        pin_dir = 13'h0000;
        errors = 0;
        comparisons = 0;
        cycles = 0;
        pulses = 0;
        step(5);
        rst_n <= 1'b1;
        #1 check(leds, 13'h0006);
        check(pin_oe, 13'h0000);
        t_leds();
        t_restore();
        t_sleep();
        t_pins();
        close_out();
    end
endmodule // module_reset_status_control_test

`default_nettype wire
